// file: adc_ctrl_pkg.sv
package adc_ctrl_pkg;

  // ==========================================================================
  // Register map (byte addresses on the APB)
  // ==========================================================================
  localparam int             ADDR_W       = 8;
  localparam logic [7:0]     OFF_CON1     = 8'h00;
  localparam logic [7:0]     OFF_CON2     = 8'h04;
  localparam logic [7:0]     OFF_CON3     = 8'h08;
  localparam logic [7:0]     OFF_BUF      = 8'h40;  // 16 result words, 0x40..0x7C
  localparam logic [15:0]    CON_RST      = 16'h0000;

  // ==========================================================================
  // Control word one fields
  // ==========================================================================
  localparam int BIT_ON        = 15;
  localparam int BIT_HALT_IDLE = 13;
  localparam int BIT_WIDE      = 10;
  localparam int BIT_FORM_LO   = 8;
  localparam int BIT_TRIG_LO   = 5;
  localparam int BIT_SIMUL     = 3;
  localparam int BIT_AUTO      = 2;
  localparam int BIT_SAMPLE    = 1;
  localparam int BIT_DONE      = 0;

  // Control word two / three fields
  localparam int BIT_CHAN_LO   = 8;
  localparam int BIT_SPI_LO    = 2;
  localparam int BIT_SAMC_LO   = 8;
  localparam int BIT_DIV_LO    = 0;

  // ==========================================================================
  // Field widths and sizes
  // ==========================================================================
  localparam int FORM_W   = 2;
  localparam int TRIG_W   = 3;
  localparam int CHAN_W   = 2;
  localparam int SPI_W    = 4;
  localparam int SAMC_W   = 5;
  localparam int DIV_W    = 8;
  localparam int RAW_W    = 12;
  localparam int NARROW_W = 10;
  localparam int WORD_W   = 16;
  localparam int BUF_DEPTH = 16;
  localparam int PTR_W    = 4;
  localparam int NUM_SH   = 4;

  // ==========================================================================
  // Encodings
  // ==========================================================================
  localparam logic [2:0] TRIG_MANUAL = 3'h0;
  localparam logic [2:0] TRIG_EXTPIN = 3'h1;
  localparam logic [2:0] TRIG_TIMER3 = 3'h2;
  localparam logic [2:0] TRIG_PWM1   = 3'h3;
  localparam logic [2:0] TRIG_PWM2   = 3'h5;
  localparam logic [2:0] TRIG_AUTO   = 3'h7;

  localparam logic [1:0] FMT_INT   = 2'h0;
  localparam logic [1:0] FMT_SINT  = 2'h1;
  localparam logic [1:0] FMT_FRAC  = 2'h2;
  localparam logic [1:0] FMT_SFRAC = 2'h3;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_SAMPLE, SEQ_START, SEQ_WAIT} seq_state_t;

endpackage

// file: format_if.sv
`timescale 1ns/1ps
// ============================================================================
// Raw sample in, justified result word out
// ============================================================================
interface format_if;
  import adc_ctrl_pkg::*;
  logic [RAW_W-1:0]  raw;
  logic              wide;
  logic [FORM_W-1:0] format;
  logic [WORD_W-1:0] word;
  modport src (output raw, output wide, output format, input word);
  modport fmt (input raw, input wide, input format, output word);
endinterface

// file: result_formatter.sv
`timescale 1ns/1ps
// ============================================================================
// Result justification
// ============================================================================
module result_formatter
  import adc_ctrl_pkg::*;
(
  format_if.fmt f
);
  localparam int NPAD = WORD_W - NARROW_W;
  localparam int WPAD = WORD_W - RAW_W;

  logic [NARROW_W-1:0] d10;
  logic [RAW_W-1:0]    d12;
  logic                s10;
  logic                s12;

  // Sign is the inverted top data bit
  assign d10 = f.raw[NARROW_W-1:0];
  assign d12 = f.raw;
  assign s10 = ~d10[NARROW_W-1];
  assign s12 = ~d12[RAW_W-1];

  // Four layouts per resolution
  always_comb begin
    if (f.wide) begin                                                 // [R6]
      case (f.format)
        FMT_INT:  f.word = {{WPAD{1'b0}}, d12};
        FMT_SINT: f.word = {{(WPAD+1){s12}}, d12[RAW_W-2:0]};
        FMT_FRAC: f.word = {d12, {WPAD{1'b0}}};
        default:  f.word = {s12, d12[RAW_W-2:0], {WPAD{1'b0}}};
      endcase
    end else begin                                                    // [R5]
      case (f.format)
        FMT_INT:  f.word = {{NPAD{1'b0}}, d10};
        FMT_SINT: f.word = {{(NPAD+1){s10}}, d10[NARROW_W-2:0]};
        FMT_FRAC: f.word = {d10, {NPAD{1'b0}}};
        default:  f.word = {s10, d10[NARROW_W-2:0], {NPAD{1'b0}}};
      endcase
    end
  end
endmodule // result_formatter

// file: conv_clock_divider.sv
`timescale 1ns/1ps
// ============================================================================
// Conversion clock period enable
// ============================================================================
module conv_clock_divider
  import adc_ctrl_pkg::*;
#(
  parameter int W = DIV_W
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         enable,
  input  wire logic [W-1:0] divide,
  output logic              tick
);
  logic [W-1:0] cnt_reg;

  // One tick every divide+1 cycles; restarts when disabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= '0;
    end else if (!enable || cnt_reg == divide) begin                  // [R20]
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  assign tick = enable && (cnt_reg == divide);
endmodule // conv_clock_divider

// file: adc_sample_convert_control.sv
`timescale 1ns/1ps
// How it works
// R1: Wide select gives 12-bit single channel
// R2: Resolution changes only while converter off
// R3: On bit runs converter, resets off
// R4: Halt-in-idle freezes sequencer during idle
// R5: 10-bit results in four layouts
// R6: 12-bit results in same four layouts
// R7: Trigger field picks sample-ending event
// R8: Simultaneous bit tracks channels together
// R9: Simultaneous bit reads zero when wide
// R10: Auto start resamples after each sequence
// R11: Sample bit shows tracking, software sets
// R12: Manual clear or trigger ends sampling
// R13: Done set at finish, cleared on start
// R14: Software clears done, conversions unaffected
// R15: Wide mode never samples several channels
// R16: Results kept in sixteen-word buffer
// R17: Software configures first, then enables
// R18: Channel count converts one, two, four
// R19: Auto sample time counts conversion clocks
// R20: Conversion clock is divider plus one
// R21: Interrupt every Nth finished sequence
// R22: Off converter ignores triggers and sample-bit writes
// R23: Trigger ends sampling, conversion next cycle
module adc_sample_convert_control
  import adc_ctrl_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              idle_mode,
  input  wire logic              external_interrupt_pin_zero,
  input  wire logic              timer3_match,
  input  wire logic              pwm1_interval,
  input  wire logic              pwm2_interval,
  output logic      [NUM_SH-1:0] track_mask,
  output logic                   convert_start,
  output logic      [CHAN_W-1:0] convert_channel,
  input  wire logic              convert_done,
  input  wire logic [RAW_W-1:0]  convert_data,
  output logic                   converter_interrupt_flag
);

  // ==========================================================================
  // Declarations
  // ==========================================================================
  logic              on_reg, halt_idle_reg, wide_reg, simul_reg, auto_reg, done_reg;
  logic [FORM_W-1:0] format_reg;
  logic [TRIG_W-1:0] trig_reg;
  logic [CHAN_W-1:0] chan_reg;
  logic [SPI_W-1:0]  spi_reg, seq_cnt_reg;
  logic [SAMC_W-1:0] samc_reg, sample_active_cnt_reg;
  logic [DIV_W-1:0]  div_reg;
  logic [PTR_W-1:0]  wr_ptr_reg;
  logic [CHAN_W-1:0] chan_idx_reg, last_idx;
  logic [WORD_W-1:0] buf_reg [BUF_DEPTH];
  logic [NUM_SH-1:0] used_mask, track_next;
  seq_state_t        state_reg, state_next;
  logic              ext_prev_reg, ext_rise, hw_trig, trigger_hit, running, tick;
  logic              apb_wr, wr_con1, sw_set_sample, sw_clear_sample, store, seq_end;
  logic              mapped, is_buf;
  logic [WORD_W-1:0] con1_read, rd_word;
  logic [31:0]       prdata_reg;
  logic              pslverr_reg, irq_reg, start_reg;

  format_if fbus ();
  result_formatter u_fmt (.f(fbus));

  // Divider only runs while sampling so the sample time starts clean
  conv_clock_divider #(.W(DIV_W)) u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .enable  (state_reg == SEQ_SAMPLE && running),
    .divide  (div_reg),
    .tick    (tick)
  );

  // ==========================================================================
  // APB decode
  // ==========================================================================
  assign is_buf  = paddr[ADDR_W-1:PTR_W+2] == OFF_BUF[ADDR_W-1:PTR_W+2];
  assign mapped  = (paddr[1:0] == 2'h0) &&
                   (paddr == OFF_CON1 || paddr == OFF_CON2 || paddr == OFF_CON3 || is_buf);
  assign apb_wr  = psel && penable && pwrite && mapped;
  assign wr_con1 = apb_wr && paddr == OFF_CON1;
  assign pready  = 1'b1;  // Zero wait states, read data latched in setup

  // Software sample-bit actions only count while running
  assign sw_set_sample   = wr_con1 && pwdata[BIT_SAMPLE] && !auto_reg;         // [R11]
  assign sw_clear_sample = wr_con1 && !pwdata[BIT_SAMPLE];                     // [R12]

  // Control word one readback; sample bit mirrors the tracking phase
  always_comb begin
    con1_read                              = CON_RST;
    con1_read[BIT_ON]                      = on_reg;
    con1_read[BIT_HALT_IDLE]               = halt_idle_reg;
    con1_read[BIT_WIDE]                    = wide_reg;
    con1_read[BIT_FORM_LO +: FORM_W]       = format_reg;
    con1_read[BIT_TRIG_LO +: TRIG_W]       = trig_reg;
    con1_read[BIT_SIMUL]                   = simul_reg && !wide_reg;          // [R9]
    con1_read[BIT_AUTO]                    = auto_reg;
    con1_read[BIT_SAMPLE]                  = state_reg == SEQ_SAMPLE;         // [R11]
    con1_read[BIT_DONE]                    = done_reg;
  end

  // Read mux; channel count reads zero in wide mode
  always_comb begin
    rd_word = CON_RST;
    if (paddr == OFF_CON1) begin
      rd_word = con1_read;
    end else if (paddr == OFF_CON2) begin
      rd_word[BIT_CHAN_LO +: CHAN_W] = wide_reg ? '0 : chan_reg;
      rd_word[BIT_SPI_LO +: SPI_W]   = spi_reg;
    end else if (paddr == OFF_CON3) begin
      rd_word[BIT_SAMC_LO +: SAMC_W] = samc_reg;
      rd_word[BIT_DIV_LO +: DIV_W]   = div_reg;
    end else if (is_buf) begin
      rd_word = buf_reg[paddr[PTR_W+1:2]];
    end
  end

  // Read data and error captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg  <= '0;
      pslverr_reg <= 1'b0;
    end else if (psel && !penable) begin
      prdata_reg  <= (mapped && !pwrite) ? {16'h0000, rd_word} : '0;
      pslverr_reg <= !mapped;
    end
  end
  assign prdata  = prdata_reg;
  assign pslverr = pslverr_reg;

  // ==========================================================================
  // Configuration registers
  // ==========================================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_reg        <= 1'b0;                                                  // [R3]
      halt_idle_reg <= 1'b0;
      wide_reg      <= 1'b0;                                                  // [R1]
      format_reg    <= '0;
      trig_reg      <= TRIG_MANUAL;
      simul_reg     <= 1'b0;
      auto_reg      <= 1'b0;
    end else if (wr_con1) begin
      on_reg        <= pwdata[BIT_ON];                                        // [R3]
      halt_idle_reg <= pwdata[BIT_HALT_IDLE];
      // Resolution change while on would corrupt a sequence, so ignored
      if (!on_reg) begin
        wide_reg <= pwdata[BIT_WIDE];                                         // [R2]
      end
      format_reg    <= pwdata[BIT_FORM_LO +: FORM_W];
      trig_reg      <= pwdata[BIT_TRIG_LO +: TRIG_W];
      simul_reg     <= pwdata[BIT_SIMUL];
      auto_reg      <= pwdata[BIT_AUTO];
    end
  end

  // Control words two and three
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_reg <= '0;
      spi_reg  <= '0;
      samc_reg <= '0;
      div_reg  <= '0;
    end else if (apb_wr && paddr == OFF_CON2) begin
      chan_reg <= pwdata[BIT_CHAN_LO +: CHAN_W];
      spi_reg  <= pwdata[BIT_SPI_LO +: SPI_W];
    end else if (apb_wr && paddr == OFF_CON3) begin
      samc_reg <= pwdata[BIT_SAMC_LO +: SAMC_W];
      div_reg  <= pwdata[BIT_DIV_LO +: DIV_W];
    end
  end

  // ==========================================================================
  // Trigger selection
  // ==========================================================================
  assign running  = on_reg && !(halt_idle_reg && idle_mode);                  // [R4]
  assign ext_rise = external_interrupt_pin_zero && !ext_prev_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_prev_reg <= 1'b0;
    end else begin
      ext_prev_reg <= external_interrupt_pin_zero;
    end
  end

  // Reserved codes never end sampling
  always_comb begin
    case (trig_reg)                                                           // [R7]
      TRIG_MANUAL: hw_trig = sw_clear_sample;                                 // [R12]
      TRIG_EXTPIN: hw_trig = ext_rise;
      TRIG_TIMER3: hw_trig = timer3_match;
      TRIG_PWM1:   hw_trig = pwm1_interval;
      TRIG_PWM2:   hw_trig = pwm2_interval;
      TRIG_AUTO:   hw_trig = sample_active_cnt_reg >= samc_reg;                        // [R19]
      default:     hw_trig = 1'b0;
    endcase
  end
  assign trigger_hit = state_reg == SEQ_SAMPLE && running && hw_trig;         // [R23]

  // Sample time in conversion clock periods
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_active_cnt_reg <= '0;
    end else if (state_reg != SEQ_SAMPLE) begin
      sample_active_cnt_reg <= '0;
    end else if (tick && sample_active_cnt_reg < samc_reg) begin                       // [R19]
      sample_active_cnt_reg <= sample_active_cnt_reg + 1'b1;
    end
  end

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  assign last_idx = wide_reg ? '0 : (chan_reg[1] ? 2'h3 : {1'b0, chan_reg[0]}); // [R18] [R1]
  assign store    = state_reg == SEQ_WAIT && running && convert_done;
  assign seq_end  = store && chan_idx_reg == last_idx;

  always_comb begin
    state_next = state_reg;
    if (!on_reg) begin
      state_next = SEQ_IDLE;                                                  // [R22]
    end else if (running) begin
      case (state_reg)
        SEQ_IDLE:   if (sw_set_sample || auto_reg) state_next = SEQ_SAMPLE;   // [R10] [R11]
        SEQ_SAMPLE: if (trigger_hit) state_next = SEQ_START;                  // [R23]
        SEQ_START:  state_next = SEQ_WAIT;
        SEQ_WAIT: begin
          if (seq_end) begin
            state_next = auto_reg ? SEQ_SAMPLE : SEQ_IDLE;                    // [R10]
          end else if (store) begin
            state_next = SEQ_START;
          end
        end
        default:    state_next = SEQ_IDLE;
      endcase
    end
  end

  // Held in place while halted in idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= SEQ_IDLE;
    end else begin
      state_reg <= state_next;                                                // [R4]
    end
  end

  // Channel walk through one sequence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_idx_reg <= '0;
    end else if (state_next == SEQ_SAMPLE || state_next == SEQ_IDLE) begin
      chan_idx_reg <= '0;
    end else if (store && !seq_end) begin
      chan_idx_reg <= chan_idx_reg + 1'b1;                                    // [R18]
    end
  end

  // Start strobe and channel for the analog core
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_reg       <= 1'b0;
      convert_channel <= '0;
    end else begin
      start_reg       <= state_next == SEQ_START && state_reg != SEQ_START;
      convert_channel <= (state_next == SEQ_SAMPLE) ? '0 :
                         ((store && !seq_end) ? chan_idx_reg + 1'b1 : chan_idx_reg);
    end
  end
  assign convert_start = start_reg;

  // Tracking mask; wide mode has a single amplifier
  assign used_mask  = chan_reg[1] ? 4'hF : (chan_reg[0] ? 4'h3 : 4'h1);
  assign track_next = (state_next != SEQ_SAMPLE) ? 4'h0 :
                      ((simul_reg && !wide_reg) ? used_mask : 4'h1);          // [R8] [R15]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      track_mask <= '0;
    end else begin
      track_mask <= track_next;
    end
  end

  // Completion flag: hardware set beats every clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_reg <= 1'b0;
    end else if (seq_end) begin
      done_reg <= 1'b1;                                                       // [R13]
    end else if (state_reg == SEQ_START && chan_idx_reg == '0 && running) begin
      done_reg <= 1'b0;                                                       // [R13]
    end else if (wr_con1 && !pwdata[BIT_DONE]) begin
      done_reg <= 1'b0;                                                       // [R14]
    end
  end

  // ==========================================================================
  // Result buffer and sequence count
  // ==========================================================================
  assign fbus.raw    = convert_data;
  assign fbus.wide   = wide_reg;
  assign fbus.format = format_reg;

  // Fill restarts at word zero after each interrupt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_reg  <= '0;
      seq_cnt_reg <= '0;
      irq_reg     <= 1'b0;
    end else begin
      irq_reg <= seq_end && seq_cnt_reg == spi_reg;                           // [R21]
      if (seq_end && seq_cnt_reg == spi_reg) begin
        wr_ptr_reg  <= '0;
        seq_cnt_reg <= '0;
      end else begin
        if (store) wr_ptr_reg <= wr_ptr_reg + 1'b1;                           // [R16]
        if (seq_end) seq_cnt_reg <= seq_cnt_reg + 1'b1;
      end
    end
  end
  assign converter_interrupt_flag = irq_reg;

  // One entry per generated slot
  for (genvar i = 0; i < BUF_DEPTH; i++) begin : g_buf
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        buf_reg[i] <= '0;
      end else if (store && wr_ptr_reg == PTR_W'(i)) begin
        buf_reg[i] <= fbus.word;                                              // [R16] [R5] [R6]
      end
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_off_stays_idle: assert property (!on_reg && $past(!on_reg) |-> state_reg == SEQ_IDLE) // [R22]
    else $error("sequencer active while converter off");
  a_trigger_starts: assert property (trigger_hit |=> state_reg == SEQ_START && convert_start) // [R23]
    else $error("trigger did not start conversion next cycle");
  a_done_on_finish: assert property (seq_end |=> done_reg) // [R13]
    else $error("done not set after sequence end");
  a_done_sw_clear: assert property (wr_con1 && !pwdata[BIT_DONE] && !seq_end |=> !done_reg) // [R14]
    else $error("software clear of done lost");
  a_auto_resample: assert property (seq_end && auto_reg && on_reg |=> state_reg == SEQ_SAMPLE) // [R10]
    else $error("auto start did not resample");
  a_wide_one_chan: assert property (wide_reg |-> convert_channel == '0 && track_mask[3:1] == '0) // [R15]
    else $error("wide mode used several channels");
  a_simul_read_zero: assert property (wide_reg |-> !con1_read[BIT_SIMUL]) // [R9]
    else $error("simultaneous bit visible in wide mode");
  a_irq_every_n: assert property (converter_interrupt_flag |->
      $past(seq_end) && $past(seq_cnt_reg) == $past(spi_reg)) // [R21]
    else $error("interrupt not on Nth sequence");
  a_idle_freeze: assert property (on_reg && halt_idle_reg && idle_mode ##1 on_reg
      |-> state_reg == $past(state_reg)) // [R4]
    else $error("sequencer moved while halted in idle");
  a_manual_end: assert property (state_reg == SEQ_SAMPLE && running && trig_reg == TRIG_MANUAL
      && sw_clear_sample |=> !con1_read[BIT_SAMPLE]) // [R12]
    else $error("manual clear did not end sampling");

  c_manual_seq:  cover property (trig_reg == TRIG_MANUAL && seq_end);
  c_auto_loop:   cover property (seq_end && auto_reg ##[1:200] seq_end);
  c_simul_four:  cover property (track_mask == 4'hF);
  c_irq_pulse:   cover property (converter_interrupt_flag && spi_reg != '0);

endmodule // adc_sample_convert_control

// file: core_model.sv
`timescale 1ns/1ps
// ==========================================
// Converter core stand-in
// ==========================================
module core_model (
  input  wire logic        pclk,
  input  wire logic        convert_start,
  input  wire logic [11:0] value,
  input  wire logic [3:0]  lat,
  output logic             convert_done,
  output logic [11:0]      convert_data
);
  // Answers lat cycles after a start; data lines scramble outside the done cycle
  initial begin
    convert_done = 1'b0;
    convert_data = 12'h000;
    forever begin
      @(posedge pclk);
      if (convert_start === 1'b1) begin
        repeat (lat) @(posedge pclk);
        convert_done <= 1'b1;
        convert_data <= value;
        @(posedge pclk);
        convert_done <= 1'b0;
        convert_data <= ~value;
      end
    end
  end
endmodule // core_model

// file: testbench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin errors++; \
  $display("FAIL %0t: got %h want %h", $time, a, b); end end
module testbench;
  import adc_ctrl_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, start, done, irq, e, idle;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r, seed;
  logic [3:0]  trig, lat, track_mask;
  logic [1:0]  chan;
  logic [11:0] value, cdata;
  logic [15:0] cfg;
  logic [2:0]  codes [4];
  int          errors, n_compared, n_irq, i, k, w, n_done, ch_exp, d0, i0;
  int          n_ch = 1, m_exp = 1;
  // ==========================================
  // Clock, design and core
  // ==========================================
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  adc_sample_convert_control dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .idle_mode(idle),
    .external_interrupt_pin_zero(trig[0]), .timer3_match(trig[1]), .pwm1_interval(trig[2]),
    .pwm2_interval(trig[3]), .track_mask(track_mask), .convert_start(start),
    .convert_channel(chan), .convert_done(done), .convert_data(cdata),
    .converter_interrupt_flag(irq));
  core_model core (.pclk(pclk), .convert_start(start), .value(value), .lat(lat),
    .convert_done(done), .convert_data(cdata));
  // Counts and checks at mid-cycle, where outputs are settled
  always @(negedge pclk) begin
    n_irq += (irq === 1'b1);
    n_done += (done === 1'b1);
    if (track_mask !== 4'h0) `CHK(track_mask, 4'(m_exp))
    if (start === 1'b1) begin
      `CHK(chan, 2'(ch_exp))
      ch_exp = (ch_exp + 1) % n_ch;
    end
  end
  // ==========================================
  // Helpers
  // ==========================================
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Reference layout of a raw sample
  function automatic logic [15:0] fmt(input logic wd, input logic [1:0] f, input logic [11:0] d);
    case ({wd, f})
      3'h0: return {6'h00, d[9:0]};
      3'h1: return {{7{~d[9]}}, d[8:0]};
      3'h2: return {d[9:0], 6'h00};
      3'h3: return {~d[9], d[8:0], 6'h00};
      3'h4: return {4'h0, d};
      3'h5: return {{5{~d[11]}}, d[10:0]};
      3'h6: return {d, 4'h0};
      default: return {~d[11], d[10:0], 4'h0};
    endcase
  endfunction
  task results();
    $display("errors=%0d compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [15:0] d);
    int j;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, 16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (j = 0; j < 16; j++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    r = prdata;
    e = pslverr;
    if (j == 16) begin
      errors++;
      results();
    end
    {psel, penable} <= 2'b00;
  endtask
  // Watchdog against a hung run
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    results();
  end
  // ==========================================
  // Main sequence
  // ==========================================
  initial begin
    {psel, penable, pwrite, paddr, pwdata, trig, idle, presetn} = '0;
    {value, lat, seed} = {12'h000, 4'h1, 32'hF427};
    codes = '{TRIG_EXTPIN, TRIG_TIMER3, TRIG_PWM1, TRIG_PWM2};
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFF_CON1, 16'h0000);
    `CHK(r, 32'h0000_0000)
    apb(1'b1, OFF_CON3, 16'h0003);
    for (w = 0; w < 2; w++) begin
      apb(1'b1, OFF_CON1, 16'h0000);
      apb(1'b1, OFF_CON1, 16'(w << BIT_WIDE));
      for (k = 0; k < 8; k++) begin
        value = 12'(xs() & (w ? 32'hFFF : 32'h3FF));
        lat = 4'(1 + xs() % 8);
        cfg = 16'h8008 | 16'(w << BIT_WIDE) | 16'((k % 4) << BIT_FORM_LO);
        cfg |= (k < 4) ? 16'h0000 : 16'(codes[k - 4] << BIT_TRIG_LO);
        apb(1'b1, OFF_CON1, cfg);
        apb(1'b1, OFF_CON1, cfg | 16'h0002);
        apb(1'b0, OFF_CON1, 16'h0000);
        `CHK(r[1], 1'b1)
        `CHK(track_mask[0], 1'b1)
        `CHK(r[BIT_WIDE], w[0])
        `CHK(r[BIT_SIMUL], ~w[0])
        if (k < 4) apb(1'b1, OFF_CON1, cfg);
        else begin
          trig[k - 4] <= 1'b1;
          @(posedge pclk);
          trig <= 4'h0;
        end
        for (i = 0; i < 40 && r[0] !== 1'b1; i++) apb(1'b0, OFF_CON1, 16'h0000);
        `CHK(r[0], 1'b1)
        apb(1'b0, OFF_BUF, 16'h0000);
        `CHK(r[15:0], fmt(w[0], 2'(k % 4), value))
        apb(1'b1, OFF_CON1, cfg);
        apb(1'b0, OFF_CON1, 16'h0000);
        `CHK(r[0], 1'b0)
      end
    end
    apb(1'b1, OFF_CON1, 16'h8000);
    apb(1'b0, OFF_CON1, 16'h0000);
    `CHK(r[BIT_WIDE], 1'b1)
    // Frozen in idle
    apb(1'b1, OFF_CON1, 16'hA002);
    idle <= 1'b1;
    apb(1'b1, OFF_CON1, 16'hA000);
    apb(1'b0, OFF_CON1, 16'h0000);
    `CHK(r[1], 1'b1)
    idle <= 1'b0;
    apb(1'b1, OFF_CON1, 16'hA000);
    for (i = 0; i < 40 && r[0] !== 1'b1; i++) apb(1'b0, OFF_CON1, 16'h0000);
    `CHK(r[0], 1'b1)
    `CHK(n_irq, 17)
    // Four simultaneous channels, auto restart
    repeat (2) apb(1'b1, OFF_CON1, 16'h0000);
    apb(1'b1, OFF_CON2, 16'h0204);
    n_ch = 4;
    m_exp = 15;
    d0 = n_done;
    i0 = n_irq;
    value = 12'(xs() & 32'h3FF);
    apb(1'b1, OFF_CON1, 16'h80EC);
    repeat (150) @(posedge pclk);
    apb(1'b1, OFF_CON1, 16'h80E8);
    repeat (120) @(posedge pclk);
    apb(1'b0, OFF_CON1, 16'h0000);
    `CHK(r[1:0], 2'h1)
    `CHK(n_irq - i0, (n_done - d0) / 8)
    for (i = 0; i < 8; i++) begin
      apb(1'b0, 8'(OFF_BUF + 4 * i), 16'h0000);
      `CHK({e, r[15:0]}, {1'b0, fmt(1'b0, 2'h0, value)})
    end
    apb(1'b0, 8'h80, 16'h0000);
    `CHK({e, r}, {1'b1, 32'h0})
    apb(1'b1, OFF_CON1, 16'h0000);
    apb(1'b1, OFF_CON1, 16'h0002);
    apb(1'b0, OFF_CON1, 16'h0000);
    `CHK(r[1], 1'b0)
    results();
  end
endmodule // testbench
